// file: dv/i2c_ctl_model.sv
`timescale 1ns/1ps
module i2c_ctl_model (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_oe,
	output logic      sda_oe
);
	// quarter of one scl period, changed by the bench for high speed operation
	realtime q = 100.0;

	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end

	// ----------------------------------------
	// bus conditions
	// ----------------------------------------
	// from idle or from clock low: works as start and as repeated start
	task automatic start_cond();
		sda_oe = 1'b0;
		#q;
		scl_oe = 1'b0;
		#(2*q);
		sda_oe = 1'b1;
		#(2*q);
		scl_oe = 1'b1;
		#q;
	endtask

	task automatic stop_cond();
		sda_oe = 1'b1;
		#q;
		scl_oe = 1'b0;
		#(2*q);
		sda_oe = 1'b0;
		#(2*q);
	endtask

	// ----------------------------------------
	// bit and byte transfers
	// ----------------------------------------
	task automatic clk_bit(output logic s);
		#q;
		scl_oe = 1'b0;
		#q;
		s = sda;
		#q;
		scl_oe = 1'b1;
		#q;
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			sda_oe = ~b[i];
			clk_bit(s);
		end
		sda_oe = 1'b0;
		clk_bit(s);
		ack = ~s;
	endtask

	task automatic recv_byte(input logic last, output logic [7:0] b);
		logic s;
		sda_oe = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(s);
			b[i] = s;
		end
		sda_oe = ~last;
		clk_bit(s);
		sda_oe = 1'b0;
	endtask
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
	localparam logic [6:0] DEV_ADDR = 7'h2A;
	logic       sys_clk, rst_n, link_clk, conv_valid, alert_hold, over_clear, under_clear;
	logic [6:0] own_addr;
	logic [9:0] conv_result, upper_thr, lower_thr;
	logic [2:0] cycle_time;
	logic       scl_out, scl_oe, sda_out, sda_oe, hs_mode, over_alert, under_alert;
	logic       m_scl_oe, m_sda_oe, hs_seen;
	wire        scl_w = ~(m_scl_oe | scl_oe);
	wire        sda_w = ~(m_sda_oe | sda_oe);
	int         fails = 0;
	int         total_checks = 0;

	i2c_limit_target u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl_w),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.own_addr(own_addr), .hs_mode(hs_mode), .conv_valid(conv_valid), .conv_result(conv_result),
		.cycle_time(cycle_time), .alert_hold(alert_hold), .upper_limit_threshold(upper_thr),
		.lower_limit_threshold(lower_thr), .over_clear(over_clear), .under_clear(under_clear),
		.over_alert(over_alert), .under_alert(under_alert));

	i2c_ctl_model u_ctl (.scl(scl_w), .sda(sda_w), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

	// ----------------------------------------
	// clocks
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] fld(input logic [9:0] v);
		return {4'h0, v, 2'b00};
	endfunction

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] w);
		logic [3:0] acks;
		u_ctl.start_cond();
		u_ctl.send_byte({DEV_ADDR, 1'b0}, acks[3]);
		u_ctl.send_byte(ptr, acks[2]);
		u_ctl.send_byte(w[15:8], acks[1]);
		u_ctl.send_byte(w[7:0], acks[0]);
		u_ctl.stop_cond();
		chk("write acks", 16'h000F, {12'h0, acks});
	endtask

	task automatic rd_reg(input logic [7:0] ptr, output logic [15:0] w);
		logic [2:0] acks;
		u_ctl.start_cond();
		u_ctl.send_byte({DEV_ADDR, 1'b0}, acks[2]);
		u_ctl.send_byte(ptr, acks[1]);
		u_ctl.start_cond();
		hs_seen = hs_mode;
		u_ctl.send_byte({DEV_ADDR, 1'b1}, acks[0]);
		u_ctl.recv_byte(1'b0, w[15:8]);
		u_ctl.recv_byte(1'b1, w[7:0]);
		u_ctl.stop_cond();
		chk("read acks", 16'h0007, {13'h0, acks});
	endtask

	task automatic chk_reg(input string what, input logic [7:0] ptr, input logic [15:0] exp);
		logic [15:0] w;
		rd_reg(ptr, w);
		chk(what, exp, w);
	endtask

	task automatic conv(input logic [9:0] v, input logic e_over, input logic e_under);
		@(posedge sys_clk);
		conv_valid <= 1'b1;
		conv_result <= v;
		@(posedge sys_clk);
		conv_valid <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("alerts", {14'h0, e_over, e_under}, {14'h0, over_alert, under_alert});
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk_reg("margin reset", 8'h05, 16'h0000);
		chk_reg("min reset", 8'h06, 16'h0FFC);
		chk_reg("max reset", 8'h07, 16'h0000);
		chk("pin drive", 16'h0000, {13'h0, scl_out, scl_oe, sda_out});
		$display("test reset done");
	endtask

	task automatic t_addr();
		logic a;
		u_ctl.start_cond();
		u_ctl.send_byte({DEV_ADDR ^ 7'h01, 1'b1}, a);
		u_ctl.stop_cond();
		chk("foreign address ack", 16'h0000, {15'h0, a});
		$display("test address done");
	endtask

	task automatic t_margin();
		wr_reg(8'h05, 16'hF5A7);
		chk_reg("margin field", 8'h05, 16'h05A4);
		$display("test margin done");
	endtask

	task automatic t_hs();
		logic        a;
		logic [15:0] w;
		u_ctl.start_cond();
		u_ctl.send_byte(8'h0B, a);
		chk("hs code ack", 16'h0000, {15'h0, a});
		chk("hs flag set", 16'h0001, {15'h0, hs_mode});
		u_ctl.q = 50.0;
		rd_reg(8'h05, w);
		chk("hs read", 16'h05A4, w);
		chk("hs kept", 16'h0001, {15'h0, hs_seen});
		repeat (10) @(posedge sys_clk);
		chk("hs cleared by stop", 16'h0000, {15'h0, hs_mode});
		u_ctl.q = 100.0;
		$display("test high speed done");
	endtask

	task automatic t_track();
		@(posedge sys_clk) cycle_time <= 3'h0;
		conv(10'h123, 1'b0, 1'b0);
		chk_reg("min normal mode", 8'h06, 16'h0FFC);
		chk_reg("max normal mode", 8'h07, 16'h0000);
		@(posedge sys_clk) cycle_time <= 3'h1;
		conv(10'h155, 1'b0, 1'b0);
		conv(10'h3FF, 1'b0, 1'b0);
		conv(10'h200, 1'b0, 1'b0);
		chk_reg("min tracked", 8'h06, fld(10'h155));
		chk_reg("max tracked", 8'h07, fld(10'h3FF));
		@(posedge sys_clk) cycle_time <= 3'h7;
		conv(10'h000, 1'b0, 1'b0);
		chk_reg("min to zero", 8'h06, 16'h0000);
		wr_reg(8'h06, 16'h0FFF);
		chk_reg("min cleared", 8'h06, 16'h0FFC);
		wr_reg(8'h07, 16'h0000);
		chk_reg("max cleared", 8'h07, 16'h0000);
		$display("test tracking done");
	endtask

	task automatic t_alert();
		wr_reg(8'h05, fld(10'h010));
		@(posedge sys_clk);
		upper_thr <= 10'h200;
		lower_thr <= 10'h100;
		alert_hold <= 1'b0;
		conv(10'h250, 1'b1, 1'b0);
		conv(10'h1F0, 1'b1, 1'b0);
		conv(10'h1EF, 1'b0, 1'b0);
		conv(10'h0F0, 1'b0, 1'b1);
		conv(10'h110, 1'b0, 1'b1);
		conv(10'h111, 1'b0, 1'b0);
		@(posedge sys_clk) alert_hold <= 1'b1;
		conv(10'h250, 1'b1, 1'b0);
		conv(10'h180, 1'b1, 1'b0);
		@(posedge sys_clk) over_clear <= 1'b1;
		@(posedge sys_clk) over_clear <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("explicit clear", 16'h0000, {15'h0, over_alert});
		conv(10'h0F0, 1'b0, 1'b1);
		conv(10'h180, 1'b0, 1'b1);
		@(posedge sys_clk) under_clear <= 1'b1;
		@(posedge sys_clk) under_clear <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("explicit under clear", 16'h0000, {15'h0, under_alert});
		$display("test alerts done");
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge sys_clk);
		fails++;
		$display("CHECK FAILED run length expected finish seen timeout");
		print_verdict();
	end

	initial begin
		rst_n = 1'b0;
		own_addr = DEV_ADDR;
		conv_valid = 1'b0;
		conv_result = 10'h000;
		cycle_time = 3'h0;
		alert_hold = 1'b0;
		upper_thr = 10'h3FF;
		lower_thr = 10'h000;
		over_clear = 1'b0;
		under_clear = 1'b0;
		hs_seen = 1'b0;
		repeat (2) @(posedge link_clk);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge link_clk);
		t_reset();
		t_addr();
		t_margin();
		t_hs();
		t_track();
		t_alert();
		print_verdict();
	end
endmodule

// file: hdl/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} sync_state_t;

	sync_state_t state_r;
	sync_state_t state_nxt;

	always_comb begin
		state_nxt      = state_r;
		state_nxt.meta = d;
		state_nxt.sync = state_r.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign q = state_r.sync;
endmodule

// file: hdl/i2c_limit_target.sv
`timescale 1ns/1ps
`include "limit_map.svh"
// How it works
// RULE1: alert clears once result is back inside its limit by more than margin
// RULE2: with alert hold set, hysteresis never clears an alert
// RULE3: margin field sits in word bits 11 down to 2
// RULE4: bits 15:12 and 1:0 read zero; controller writes zero there
// RULE5: new result below running minimum replaces it
// RULE6: writing 0FFFh resets running minimum; also its reset value
// RULE7: new result above running maximum replaces it
// RULE8: writing 0000h resets running maximum; also its reset value
// RULE9: trackers only update in automatic conversion mode
// RULE10: automatic mode is on when cycle time field is nonzero
// RULE11: address match is acknowledged low, mismatch left released
// RULE12: every written data byte is acknowledged
// RULE13: controller acks each read byte, nacks last then stops
// RULE14: start is data falling while clock high
// RULE15: repeated start precedes new address and direction bit
// RULE16: repeated start keeps the current speed mode
// RULE17: stop is data rising while clock high; bus then idle
// RULE18: zero is driven low, one is released to pull-up
// RULE19: standard, fast and high speed share one sampling engine
// RULE20: first written byte after address is the register pointer
// RULE21: read sends upper byte first, lower after controller ack
// RULE22: high speed code byte is not acknowledged
// RULE23: tracker compares are unsigned on the 10-bit result after each conversion
module i2c_limit_target (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       link_clk,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic [6:0] own_addr,
	output logic            hs_mode,
	input  wire logic       conv_valid,
	input  wire logic [9:0] conv_result,
	input  wire logic [2:0] cycle_time,
	input  wire logic       alert_hold,
	input  wire logic [9:0] upper_limit_threshold,
	input  wire logic [9:0] lower_limit_threshold,
	input  wire logic       over_clear,
	input  wire logic       under_clear,
	output logic            over_alert,
	output logic            under_alert
);
	lim_pkg::link_regs_t l_r;
	lim_pkg::link_regs_t l_nxt;
	lim_pkg::sys_regs_t  s_r;
	lim_pkg::sys_regs_t  s_nxt;
	logic                scl_s;
	logic                sda_s;
	logic [6:0]          own_s;
	logic                start_c;
	logic                stop_c;
	logic                rise_c;
	logic                fall_c;
	logic                rsp_v;
	logic [15:0]         rsp_d;
	logic                req_v;
	logic [24:0]         req_d;
	logic                auto_on;
	logic                wr_req;
	logic [7:0]          req_ptr;
	logic [15:0]         req_word;
	logic                hi_set;
	logic                hi_clr;
	logic                lo_set;
	logic                lo_clr;

	function automatic logic [15:0] field_word(input logic [9:0] f);
		field_word = {4'h0, f, 2'h0};
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b);
		shift_in = {s[6:0], b};
	endfunction

	// ----------------------------------------
	// link pins and framing
	// ----------------------------------------
	// oversampled on link_clk, so every speed mode takes the same path
	bit_sync #(.WIDTH(1)) u_scl_sync (.clk(link_clk), .rst_n(rst_n), .d(scl_in), .q(scl_s)); // RULE19
	bit_sync #(.WIDTH(1)) u_sda_sync (.clk(link_clk), .rst_n(rst_n), .d(sda_in), .q(sda_s));
	bit_sync #(.WIDTH(7)) u_adr_sync (.clk(link_clk), .rst_n(rst_n), .d(own_addr), .q(own_s));

	assign start_c = l_r.scl_p && scl_s && l_r.sda_p && !sda_s; // RULE14 RULE15
	assign stop_c  = l_r.scl_p && scl_s && !l_r.sda_p && sda_s; // RULE17
	assign rise_c  = !l_r.scl_p && scl_s;
	assign fall_c  = l_r.scl_p && !scl_s;

	always_comb begin
		logic [7:0]  byte_in;
		logic [15:0] word_now;
		byte_in     = shift_in(l_r.sh, sda_s);
		word_now    = rsp_v ? rsp_d : l_r.rword;
		l_nxt       = l_r;
		l_nxt.scl_p = scl_s;
		l_nxt.sda_p = sda_s;
		l_nxt.req_v = 1'h0;
		l_nxt.rword = word_now;
		if (start_c) begin
			l_nxt.st    = lim_pkg::LS_ADDR; // RULE15 RULE16
			l_nxt.cnt   = 3'h0;
			l_nxt.oe    = 1'h0;
			l_nxt.armed = 1'h0;
		end else if (stop_c) begin
			l_nxt.st = lim_pkg::LS_IDLE; // RULE17
			l_nxt.oe = 1'h0;
			l_nxt.hs = 1'h0;
		end else begin
			case (l_r.st)
			lim_pkg::LS_ADDR, lim_pkg::LS_PTR, lim_pkg::LS_WDAT: begin
				if (rise_c) begin
					l_nxt.sh  = byte_in;
					l_nxt.cnt = l_r.cnt + 3'h1;
				end
				if (rise_c && l_r.cnt == `LAST_BIT) begin
					l_nxt.armed  = 1'h0;
					l_nxt.ack_ok = 1'h1;
					if (l_r.st == lim_pkg::LS_ADDR) begin
						l_nxt.st = lim_pkg::LS_ACK_A;
						l_nxt.rd = byte_in[0];
						if (byte_in[7:3] == `HS_CODE) begin
							l_nxt.hs     = 1'h1; // RULE22
							l_nxt.ack_ok = 1'h0; // RULE22
						end else if (byte_in[7:1] != own_s) begin
							l_nxt.ack_ok = 1'h0; // RULE11
						end else if (byte_in[0]) begin
							l_nxt.req_v = 1'h1;
							l_nxt.req_d = {1'h0, l_r.ptr, 16'h0000};
						end
					end else if (l_r.st == lim_pkg::LS_PTR) begin
						l_nxt.st  = lim_pkg::LS_ACK_P;
						l_nxt.ptr = byte_in; // RULE20
					end else begin
						l_nxt.st    = lim_pkg::LS_ACK_W; // RULE12
						l_nxt.upper = ~l_r.upper;
						if (l_r.upper) begin
							l_nxt.wr_hi = byte_in;
						end else begin
							l_nxt.req_v = 1'h1;
							l_nxt.req_d = {1'h1, l_r.ptr, l_r.wr_hi, byte_in};
						end
					end
				end
			end
			lim_pkg::LS_ACK_A, lim_pkg::LS_ACK_P, lim_pkg::LS_ACK_W: begin
				if (fall_c && !l_r.armed) begin
					l_nxt.oe    = l_r.ack_ok; // RULE11 RULE12 RULE18
					l_nxt.armed = 1'h1;
				end else if (fall_c) begin
					l_nxt.oe    = 1'h0;
					l_nxt.armed = 1'h0;
					l_nxt.cnt   = 3'h0;
					if (!l_r.ack_ok) begin
						l_nxt.st = lim_pkg::LS_IDLE;
					end else if (l_r.st == lim_pkg::LS_ACK_A && l_r.rd) begin
						l_nxt.st    = lim_pkg::LS_RDAT;
						l_nxt.tx    = word_now[15:8]; // RULE21
						l_nxt.oe    = ~word_now[15];
						l_nxt.upper = 1'h0;
					end else if (l_r.st == lim_pkg::LS_ACK_A) begin
						l_nxt.st = lim_pkg::LS_PTR;
					end else begin
						l_nxt.st = lim_pkg::LS_WDAT;
						if (l_r.st == lim_pkg::LS_ACK_P) begin
							l_nxt.upper = 1'h1;
						end
					end
				end
			end
			lim_pkg::LS_RDAT: begin
				if (fall_c) begin
					l_nxt.tx = {l_r.tx[6:0], 1'h0};
					l_nxt.oe = ~l_r.tx[6]; // RULE18
				end
				if (rise_c) begin
					l_nxt.cnt = l_r.cnt + 3'h1;
					if (l_r.cnt == `LAST_BIT) begin
						l_nxt.st    = lim_pkg::LS_RACK;
						l_nxt.armed = 1'h0;
					end
				end
			end
			lim_pkg::LS_RACK: begin
				if (fall_c && !l_r.armed) begin
					l_nxt.oe    = 1'h0;
					l_nxt.armed = 1'h1;
				end else if (rise_c && l_r.armed) begin
					l_nxt.ack_ok = !sda_s; // RULE13
					if (!sda_s && l_r.upper) begin
						l_nxt.req_v = 1'h1;
						l_nxt.req_d = {1'h0, l_r.ptr, 16'h0000};
					end
				end else if (fall_c && l_r.armed) begin
					l_nxt.armed = 1'h0;
					l_nxt.cnt   = 3'h0;
					if (!l_r.ack_ok) begin
						l_nxt.st = lim_pkg::LS_IDLE; // RULE13
					end else begin
						l_nxt.st    = lim_pkg::LS_RDAT;
						l_nxt.tx    = l_r.upper ? word_now[15:8] : word_now[7:0]; // RULE21
						l_nxt.oe    = l_r.upper ? ~word_now[15] : ~word_now[7];
						l_nxt.upper = ~l_r.upper;
					end
				end
			end
			lim_pkg::LS_IDLE: begin
				l_nxt.oe = 1'h0;
			end
			default: begin
				l_nxt.st = lim_pkg::LS_IDLE;
				l_nxt.oe = 1'h0;
			end
			endcase
		end
	end

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	assign scl_out = 1'h0;
	assign scl_oe  = 1'h0;
	assign sda_out = 1'h0;
	assign sda_oe  = l_r.oe;
	assign hs_mode = l_r.hs;

	idle_release_a: assert property ( // RULE17
		@(posedge link_clk) disable iff (!rst_n)
		(l_r.st == lim_pkg::LS_IDLE) |-> !l_r.oe
	) else $error("data line driven while bus idle");

	hs_keep_a: assert property ( // RULE16
		@(posedge link_clk) disable iff (!rst_n)
		(l_r.hs && start_c) |=> (l_r.hs && l_r.st == lim_pkg::LS_ADDR)
	) else $error("repeated start dropped high speed mode");

	nack_release_a: assert property ( // RULE22
		@(posedge link_clk) disable iff (!rst_n)
		(l_r.st == lim_pkg::LS_ACK_A && !l_r.ack_ok) |-> !l_r.oe
	) else $error("unmatched or code byte acknowledged");

	addr_ack_a: assert property ( // RULE11
		@(posedge link_clk) disable iff (!rst_n)
		(l_r.st == lim_pkg::LS_ACK_A && l_r.armed && l_r.ack_ok) |-> l_r.oe
	) else $error("matched address not acknowledged");

	write_ack_a: assert property ( // RULE12
		@(posedge link_clk) disable iff (!rst_n)
		(l_r.st == lim_pkg::LS_ACK_W && l_r.armed) |-> l_r.oe
	) else $error("written byte not acknowledged");

	upper_first_a: assert property ( // RULE21
		@(posedge link_clk) disable iff (!rst_n)
		($past(l_r.st) == lim_pkg::LS_ACK_A && l_r.st == lim_pkg::LS_RDAT) |-> (l_r.tx == l_r.rword[15:8])
	) else $error("read did not start with upper byte");

	// ----------------------------------------
	// domain crossing
	// ----------------------------------------
	word_xfer #(.WIDTH(25)) u_req_xfer (
		.src_clk   (link_clk),
		.src_rst_n (rst_n),
		.src_valid (l_r.req_v),
		.src_data  (l_r.req_d),
		.dst_clk   (sys_clk),
		.dst_rst_n (rst_n),
		.dst_valid (req_v),
		.dst_data  (req_d)
	);

	word_xfer #(.WIDTH(16)) u_rsp_xfer (
		.src_clk   (sys_clk),
		.src_rst_n (rst_n),
		.src_valid (s_r.rsp_v),
		.src_data  (s_r.rsp_d),
		.dst_clk   (link_clk),
		.dst_rst_n (rst_n),
		.dst_valid (rsp_v),
		.dst_data  (rsp_d)
	);

	// ----------------------------------------
	// registers, trackers, alert clearing
	// ----------------------------------------
	assign wr_req   = req_v && req_d[`REQ_WR];
	assign req_ptr  = req_d[`REQ_PTR_HI:`REQ_PTR_LO];
	assign req_word = req_d[15:0];
	assign auto_on  = cycle_time != `CYC_OFF; // RULE10
	assign hi_set   = conv_valid && (conv_result > upper_limit_threshold);
	assign lo_set   = conv_valid && (conv_result < lower_limit_threshold);
	assign hi_clr   = conv_valid && !alert_hold && // RULE1 RULE2
		(({1'h0, conv_result} + {1'h0, s_r.margin}) < {1'h0, upper_limit_threshold});
	assign lo_clr   = conv_valid && !alert_hold && // RULE1 RULE2
		({1'h0, conv_result} > ({1'h0, lower_limit_threshold} + {1'h0, s_r.margin}));

	always_comb begin
		s_nxt       = s_r;
		s_nxt.rsp_v = 1'h0;
		if (conv_valid && auto_on) begin // RULE9
			if (conv_result < s_r.running_minimum) begin
				s_nxt.running_minimum = conv_result; // RULE5 RULE23
			end
			if (conv_result > s_r.running_maximum) begin
				s_nxt.running_maximum = conv_result; // RULE7 RULE23
			end
		end
		if (wr_req) begin
			case (req_ptr)
			`PTR_MARGIN: s_nxt.margin = req_word[`FIELD_HI:`FIELD_LO]; // RULE3
			`PTR_MIN:    s_nxt.running_minimum   = req_word[`FIELD_HI:`FIELD_LO]; // RULE6
			`PTR_MAX:    s_nxt.running_maximum   = req_word[`FIELD_HI:`FIELD_LO]; // RULE8
			default:     s_nxt.margin = s_r.margin;
			endcase
		end
		if (req_v && !wr_req) begin
			s_nxt.rsp_v = 1'h1;
			case (req_ptr)
			`PTR_MARGIN: s_nxt.rsp_d = field_word(s_r.margin); // RULE4
			`PTR_MIN:    s_nxt.rsp_d = field_word(s_r.running_minimum);
			`PTR_MAX:    s_nxt.rsp_d = field_word(s_r.running_maximum);
			default:     s_nxt.rsp_d = 16'h0000;
			endcase
		end
		// a new violation wins over any clear in the same cycle
		if (over_clear || hi_clr) begin
			s_nxt.over = 1'h0;
		end
		if (hi_set) begin
			s_nxt.over = 1'h1;
		end
		if (under_clear || lo_clr) begin
			s_nxt.under = 1'h0;
		end
		if (lo_set) begin
			s_nxt.under = 1'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r        <= '0;
			s_r.margin <= `MARGIN_RESET;
			s_r.running_minimum   <= `MIN_RESET; // RULE6
			s_r.running_maximum   <= `MAX_RESET; // RULE8
		end else begin
			s_r <= s_nxt;
		end
	end

	assign over_alert  = s_r.over;
	assign under_alert = s_r.under;

	min_track_a: assert property ( // RULE5
		@(posedge sys_clk) disable iff (!rst_n)
		(conv_valid && auto_on && !req_v && conv_result < s_r.running_minimum) |=> (s_r.running_minimum == $past(conv_result))
	) else $error("lower result did not replace running minimum");

	max_track_a: assert property ( // RULE7
		@(posedge sys_clk) disable iff (!rst_n)
		(conv_valid && auto_on && !req_v && conv_result > s_r.running_maximum) |=> (s_r.running_maximum == $past(conv_result))
	) else $error("higher result did not replace running maximum");

	normal_hold_a: assert property ( // RULE9
		@(posedge sys_clk) disable iff (!rst_n)
		(!auto_on && !req_v) |=> ($stable(s_r.running_minimum) && $stable(s_r.running_maximum))
	) else $error("tracker moved outside automatic mode");

	min_reset_a: assert property ( // RULE6
		@(posedge sys_clk) disable iff (!rst_n)
		(wr_req && req_ptr == `PTR_MIN && req_word == `MIN_RESET_WORD) |=> (s_r.running_minimum == `MIN_RESET)
	) else $error("running minimum not reset by write");

	max_reset_a: assert property ( // RULE8
		@(posedge sys_clk) disable iff (!rst_n)
		(wr_req && req_ptr == `PTR_MAX && req_word == `MAX_RESET_WORD) |=> (s_r.running_maximum == `MAX_RESET)
	) else $error("running maximum not reset by write");

	hyst_clear_a: assert property ( // RULE1
		@(posedge sys_clk) disable iff (!rst_n)
		(s_r.over && conv_valid && !alert_hold && !hi_set &&
			(({1'h0, conv_result} + {1'h0, s_r.margin}) < {1'h0, upper_limit_threshold})) |=> !s_r.over
	) else $error("over alert not cleared past margin");

	alert_sticky_a: assert property ( // RULE2
		@(posedge sys_clk) disable iff (!rst_n)
		(s_r.under && alert_hold && !under_clear) |=> s_r.under
	) else $error("held alert cleared by itself");

	reserved_zero_a: assert property ( // RULE4
		@(posedge sys_clk) disable iff (!rst_n)
		s_r.rsp_v |-> ((s_r.rsp_d & `RSV_MASK) == 16'h0000)
	) else $error("reserved read bits not zero");
endmodule

// file: hdl/lim_pkg.sv
package lim_pkg;

	// ----------------------------------------
	// link state machine
	// ----------------------------------------
	typedef enum logic [3:0] {
		LS_IDLE  = 4'h0,
		LS_ADDR  = 4'h1,
		LS_ACK_A = 4'h2,
		LS_PTR   = 4'h3,
		LS_ACK_P = 4'h4,
		LS_WDAT  = 4'h5,
		LS_ACK_W = 4'h6,
		LS_RDAT  = 4'h7,
		LS_RACK  = 4'h8
	} link_state_t;

	typedef struct packed {
		logic        scl_p;
		logic        sda_p;
		link_state_t st;
		logic [2:0]  cnt;
		logic [7:0]  sh;
		logic [7:0]  tx;
		logic [7:0]  ptr;
		logic [7:0]  wr_hi;
		logic [15:0] rword;
		logic        ack_ok;
		logic        rd;
		logic        armed;
		logic        upper;
		logic        oe;
		logic        hs;
		logic        req_v;
		logic [24:0] req_d;
	} link_regs_t;

	typedef struct packed {
		logic [9:0]  margin;
		logic [9:0]  running_minimum;
		logic [9:0]  running_maximum;
		logic        over;
		logic        under;
		logic        rsp_v;
		logic [15:0] rsp_d;
	} sys_regs_t;

endpackage

// file: hdl/limit_map.svh
`ifndef LIMIT_MAP_SVH
`define LIMIT_MAP_SVH

// ----------------------------------------
// register pointers
// ----------------------------------------
`define PTR_MARGIN     8'h05
`define PTR_MIN        8'h06
`define PTR_MAX        8'h07

// ----------------------------------------
// reset values and field layout
// ----------------------------------------
`define MARGIN_RESET   10'h000
`define MIN_RESET      10'h3FF
`define MIN_RESET_WORD 16'h0FFF
`define MAX_RESET      10'h000
`define MAX_RESET_WORD 16'h0000
`define FIELD_HI       11
`define FIELD_LO       2
`define RSV_MASK       16'hF003

// ----------------------------------------
// link framing
// ----------------------------------------
`define HS_CODE        5'h01
`define LAST_BIT       3'h7
`define CYC_OFF        3'h0
`define REQ_WR         24
`define REQ_PTR_HI     23
`define REQ_PTR_LO     16

`endif

// file: hdl/word_xfer.sv
`timescale 1ns/1ps
module word_xfer #(
	parameter int WIDTH = 16
) (
	input  wire logic             src_clk,
	input  wire logic             src_rst_n,
	input  wire logic             src_valid,
	input  wire logic [WIDTH-1:0] src_data,
	input  wire logic             dst_clk,
	input  wire logic             dst_rst_n,
	output logic                  dst_valid,
	output logic      [WIDTH-1:0] dst_data
);
	typedef struct packed {
		logic             flag;
		logic [WIDTH-1:0] data;
	} src_state_t;

	typedef struct packed {
		logic             seen;
		logic             valid;
		logic [WIDTH-1:0] data;
	} dst_state_t;

	src_state_t src_r;
	src_state_t src_nxt;
	dst_state_t dst_r;
	dst_state_t dst_nxt;
	logic       flag_s;

	// ----------------------------------------
	// source side: hold word, toggle flag
	// ----------------------------------------
	always_comb begin
		src_nxt = src_r;
		if (src_valid) begin
			src_nxt.flag = ~src_r.flag;
			src_nxt.data = src_data;
		end
	end

	always_ff @(posedge src_clk or negedge src_rst_n) begin
		if (!src_rst_n) begin
			src_r <= '0;
		end else begin
			src_r <= src_nxt;
		end
	end

	bit_sync #(
		.WIDTH(1)
	) u_flag_sync (
		.clk   (dst_clk),
		.rst_n (dst_rst_n),
		.d     (src_r.flag),
		.q     (flag_s)
	);

	// ----------------------------------------
	// destination side: held word is stable once flag lands
	// ----------------------------------------
	always_comb begin
		dst_nxt       = dst_r;
		dst_nxt.seen  = flag_s;
		dst_nxt.valid = flag_s ^ dst_r.seen;
		if (flag_s ^ dst_r.seen) begin
			dst_nxt.data = src_r.data;
		end
	end

	always_ff @(posedge dst_clk or negedge dst_rst_n) begin
		if (!dst_rst_n) begin
			dst_r <= '0;
		end else begin
			dst_r <= dst_nxt;
		end
	end

	assign dst_valid = dst_r.valid;
	assign dst_data  = dst_r.data;
endmodule
